//--- design/fbm_pkg.sv
// Purpose: Shared constants and types for the fieldbus master run/stop control.
// Assumes: One 250 MHz clock, asynchronous active-high reset.
// Notes:   Register offsets are word addresses on a 32-bit Avalon-MM slave.
`default_nettype none
package fbm_pkg;
	// ========================================================
	// Register map
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_STAT   = 4'h1;
	localparam logic [3:0] ADDR_IRQ    = 4'h2;
	localparam logic [3:0] ADDR_MASK   = 4'h3;
	localparam logic [3:0] ADDR_ADDR   = 4'h4;
	localparam logic [3:0] ADDR_SLAVES = 4'h5;
	localparam logic [3:0] ADDR_FSAFE  = 4'h6;
	localparam logic [3:0] ADDR_OUTLEN = 4'h7;
	localparam logic [3:0] ADDR_BAUD   = 4'h8;
	localparam logic [3:0] ADDR_ALIVE  = 4'h9;
	// CTRL bit positions.
	localparam int CTRL_BUSPAR = 0;
	localparam int CTRL_CFG    = 1;
	localparam int CTRL_RUN    = 2;
	localparam int CTRL_ODIS   = 3;
	// Interrupt status bit positions.
	localparam int IRQ_FAIL = 0;
	localparam int IRQ_JOIN = 1;
	localparam int IRQ_W    = 2;
	localparam int NSLV     = 8;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
	// Baud select codes: 0 = 9.6 kBaud ... 9 = 12 MBaud.
	localparam logic [3:0] BAUD_MAX = 4'h9;
	// ========================================================
	// Timing
	localparam int CLK_MHZ  = 250;
	localparam int BLINK_MS = 250;
	localparam int BLINK_CYC = BLINK_MS * CLK_MHZ * 1000;
	localparam int CYCLE_US = 10;
	localparam int CYCLE_CYC = CYCLE_US * CLK_MHZ;
	localparam logic [5:0] ADDR_RST = 6'h02;
	// ========================================================
	// Types
	typedef enum logic [1:0] {
		ST_OFF    = 2'b00,
		ST_ONLINE = 2'b01,
		ST_XCHG   = 2'b11
	} fbm_state_t;
	typedef struct packed {
		logic       valid;
		logic [2:0] slave;
		logic       operate;
		logic       zero_len;
		logic       zero_data;
	} fbm_tel_t;
	typedef struct packed {
		logic run_led;
		logic data_exchange_indicator;
		logic err_led;
	} fbm_led_t;
endpackage
`default_nettype wire

//--- design/fbm_top.sv
// Purpose: Run/stop control of an integrated fieldbus master.
// Assumes: Host CPU drives run state and output disable via registers.
// Notes:   Telegram scheduling is abstracted to one slot per slave per cycle.
// How it works
// - After reset the master is inactive and every indicator is dark.
// - Bus parameters take it online with run lit, answering its address.
// - Valid configuration starts cyclic exchange, shown on the de lamp.
// - Only the host run bit chooses the operating behaviour.
// - In run the global command is Operate and the de lamp is steady.
// - In run each slave gets a telegram with current output data.
// - Input data is copied every cycle in both run and stop.
// - In stop the global command is Clear and the de lamp blinks.
// - In stop fail-safe slaves get a zero-length output telegram.
// - In stop other slaves get full length telegrams with zero data.
// - One common bit rate from 9.6 kBaud to 12 MBaud is used.
// - Dropped or newly joined slaves are detected automatically.
// - Output disable zeroes all slave outputs while staying in run.
// - A slave failure lights the fault lamp and raises an event.
`default_nettype none
module fbm_top (
	// Clock and reset
	input  wire logic                  sys_clk_i,
	input  wire logic                  rst_i,
	// Avalon-MM slave
	input  wire logic [3:0]            avs_address_i,
	input  wire logic                  avs_read_i,
	input  wire logic                  avs_write_i,
	input  wire logic [31:0]           avs_writedata_i,
	output logic      [31:0]           avs_readdata_o,
	output logic                       avs_waitrequest_o,
	// Slave answers, one bit per slave
	input  wire logic [7:0]            slave_resp_i,
	// Telegram strobe and indicators
	output fbm_pkg::fbm_tel_t          tel_o,
	output logic                       global_operate_o,
	output logic                       input_copy_o,
	output fbm_pkg::fbm_led_t          led_o,
	output logic                       irq_o
);
	parameter int BLINK_CYC = fbm_pkg::BLINK_CYC;
	parameter int CYCLE_CYC = fbm_pkg::CYCLE_CYC;

	// ========================================================
	// Registers
	fbm_pkg::fbm_state_t st_q, st_d;
	logic [3:0]  ctrl_q, ctrl_d;
	logic [1:0]  irq_q, irq_d;
	logic [1:0]  mask_q, mask_d;
	logic [5:0]  addr_q, addr_d;
	logic [7:0]  slv_q, slv_d;
	logic [7:0]  fs_q, fs_d;
	logic [7:0]  olen_q, olen_d;
	logic [3:0]  baud_q, baud_d;
	logic [7:0]  alive_q, alive_d;
	logic [31:0] rdata_q, rdata_d;
	logic        wait_q, wait_d;
	logic [27:0] blink_cnt_q, blink_cnt_d;
	logic        blink_q, blink_d;
	logic [15:0] cyc_cnt_q, cyc_cnt_d;
	logic        run_lat_q, run_lat_d;
	logic [2:0]  slot_q, slot_d;
	fbm_pkg::fbm_tel_t tel_q, tel_d;
	fbm_pkg::fbm_led_t led_q, led_d;
	logic        gop_q, gop_d;
	logic        icopy_q, icopy_d;
	logic        irq_out_q, irq_out_d;

	function automatic logic [31:0] pad(input logic [7:0] v);
		pad = {24'h00_0000, v};
	endfunction

	logic acc, wr;
	// A request is taken while waitrequest stands high. A write lands only
	// at the edge that completes it, so an abandoned request changes nothing.
	assign acc = (avs_read_i | avs_write_i) & wait_q;
	assign wr  = avs_write_i & ~wait_q;

	// ========================================================
	// Next-state logic
	always_comb begin
		st_d = st_q;
		ctrl_d = ctrl_q;
		mask_d = mask_q;
		addr_d = addr_q;
		slv_d = slv_q;
		fs_d = fs_q;
		olen_d = olen_q;
		baud_d = baud_q;
		rdata_d = rdata_q;
		wait_d = 1'b1;
		irq_d = irq_q;
		alive_d = alive_q;
		blink_cnt_d = blink_cnt_q + 28'h000_0001;
		blink_d = blink_q;
		cyc_cnt_d = cyc_cnt_q + 16'h0001;
		run_lat_d = run_lat_q;
		slot_d = slot_q;
		tel_d = '0;
		icopy_d = 1'b0;
		gop_d = gop_q;
		// Bus slave: one wait cycle, then answer.
		if (acc) begin
			wait_d = 1'b0;
			rdata_d = fbm_pkg::ZERO32;
			if (avs_read_i) begin
				case (avs_address_i)
				fbm_pkg::ADDR_CTRL:   rdata_d = {28'h000_0000, ctrl_q};
				fbm_pkg::ADDR_STAT:   rdata_d = {30'h0000_0000, st_q};
				fbm_pkg::ADDR_IRQ:    rdata_d = {30'h0000_0000, irq_q};
				fbm_pkg::ADDR_MASK:   rdata_d = {30'h0000_0000, mask_q};
				fbm_pkg::ADDR_ADDR:   rdata_d = {26'h000_0000, addr_q};
				fbm_pkg::ADDR_SLAVES: rdata_d = pad(slv_q);
				fbm_pkg::ADDR_FSAFE:  rdata_d = pad(fs_q);
				fbm_pkg::ADDR_OUTLEN: rdata_d = pad(olen_q);
				fbm_pkg::ADDR_BAUD:   rdata_d = {28'h000_0000, baud_q};
				fbm_pkg::ADDR_ALIVE:  rdata_d = pad(alive_q);
				default:              rdata_d = fbm_pkg::ZERO32;
				endcase
			end
		end
		if (wr) begin
			case (avs_address_i)
			fbm_pkg::ADDR_CTRL: ctrl_d = avs_writedata_i[3:0];
			fbm_pkg::ADDR_IRQ:  irq_d = irq_q & ~avs_writedata_i[1:0];
			fbm_pkg::ADDR_MASK: mask_d = avs_writedata_i[1:0];
			fbm_pkg::ADDR_ADDR: begin
				// Address 1 is kept for the system and is refused.
				if (avs_writedata_i[5:0] != 6'h01) begin
					addr_d = avs_writedata_i[5:0];
				end
			end
			fbm_pkg::ADDR_SLAVES: slv_d = avs_writedata_i[7:0];
			fbm_pkg::ADDR_FSAFE:  fs_d = avs_writedata_i[7:0];
			fbm_pkg::ADDR_OUTLEN: olen_d = avs_writedata_i[7:0];
			fbm_pkg::ADDR_BAUD: begin
				if (avs_writedata_i[3:0] <= fbm_pkg::BAUD_MAX) begin
					baud_d = avs_writedata_i[3:0];
				end
			end
			default: ;
			endcase
		end
		// Master state follows the loaded parameters only.
		case (st_q)
		fbm_pkg::ST_OFF: begin
			if (ctrl_q[fbm_pkg::CTRL_BUSPAR]) st_d = fbm_pkg::ST_ONLINE;
		end
		fbm_pkg::ST_ONLINE: begin
			if (!ctrl_q[fbm_pkg::CTRL_BUSPAR]) st_d = fbm_pkg::ST_OFF;
			else if (ctrl_q[fbm_pkg::CTRL_CFG]) st_d = fbm_pkg::ST_XCHG;
		end
		fbm_pkg::ST_XCHG: begin
			if (!ctrl_q[fbm_pkg::CTRL_BUSPAR]) st_d = fbm_pkg::ST_OFF;
			else if (!ctrl_q[fbm_pkg::CTRL_CFG]) st_d = fbm_pkg::ST_ONLINE;
		end
		default: st_d = fbm_pkg::ST_OFF;
		endcase
		if (blink_cnt_q == 28'(BLINK_CYC - 1)) begin
			blink_cnt_d = '0;
			blink_d = ~blink_q;
		end
		// Bus cycle: one slot per slave; run state latched at cycle start.
		if (cyc_cnt_q == 16'(CYCLE_CYC - 1)) begin
			cyc_cnt_d = '0;
			run_lat_d = ctrl_q[fbm_pkg::CTRL_RUN];
			slot_d = 3'h0;
			if (st_q == fbm_pkg::ST_XCHG) gop_d = ctrl_q[fbm_pkg::CTRL_RUN];
		end else if (cyc_cnt_q < 16'(fbm_pkg::NSLV)
				&& st_q == fbm_pkg::ST_XCHG) begin
			slot_d = slot_q + 3'h1;
			if (slv_q[slot_q]) begin
				tel_d.valid = 1'b1;
				tel_d.slave = slot_q;
				tel_d.operate = run_lat_q;
				tel_d.zero_len = !run_lat_q && fs_q[slot_q];
				// Zero data in stop for slaves without fail-safe, or under output disable.
				tel_d.zero_data = (!run_lat_q && !fs_q[slot_q])
					|| ctrl_q[fbm_pkg::CTRL_ODIS];
				icopy_d = slave_resp_i[slot_q];
				alive_d[slot_q] = slave_resp_i[slot_q];
				// Events set over a same-cycle clear.
				if (alive_q[slot_q] && !slave_resp_i[slot_q])
					irq_d[fbm_pkg::IRQ_FAIL] = 1'b1;
				if (!alive_q[slot_q] && slave_resp_i[slot_q])
					irq_d[fbm_pkg::IRQ_JOIN] = 1'b1;
			end
		end
		led_d.run_led = st_q != fbm_pkg::ST_OFF;
		led_d.data_exchange_indicator = st_q == fbm_pkg::ST_XCHG
			&& (run_lat_q || blink_q);
		led_d.err_led = |(slv_q & ~alive_q & slv_q);
		irq_out_d = |(irq_q & mask_q);
	end

	// ========================================================
	// Registers
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= fbm_pkg::ST_OFF;
			ctrl_q <= '0;
			irq_q <= '0;
			mask_q <= '0;
			addr_q <= fbm_pkg::ADDR_RST;
			slv_q <= '0;
			fs_q <= '0;
			olen_q <= '0;
			baud_q <= '0;
			alive_q <= '0;
			rdata_q <= '0;
			wait_q <= 1'b1;
			blink_cnt_q <= '0;
			blink_q <= 1'b0;
			cyc_cnt_q <= '0;
			run_lat_q <= 1'b0;
			slot_q <= '0;
			tel_q <= '0;
			led_q <= '0;
			gop_q <= 1'b0;
			icopy_q <= 1'b0;
			irq_out_q <= 1'b0;
		end else begin
			st_q <= st_d;
			ctrl_q <= ctrl_d;
			irq_q <= irq_d;
			mask_q <= mask_d;
			addr_q <= addr_d;
			slv_q <= slv_d;
			fs_q <= fs_d;
			olen_q <= olen_d;
			baud_q <= baud_d;
			alive_q <= alive_d;
			rdata_q <= rdata_d;
			wait_q <= wait_d;
			blink_cnt_q <= blink_cnt_d;
			blink_q <= blink_d;
			cyc_cnt_q <= cyc_cnt_d;
			run_lat_q <= run_lat_d;
			slot_q <= slot_d;
			tel_q <= tel_d;
			led_q <= led_d;
			gop_q <= gop_d;
			icopy_q <= icopy_d;
			irq_out_q <= irq_out_d;
		end
	end

	assign avs_readdata_o = rdata_q;
	assign avs_waitrequest_o = wait_q;
	assign tel_o = tel_q;
	assign led_o = led_q;
	assign global_operate_o = gop_q;
	assign input_copy_o = icopy_q;
	assign irq_o = irq_out_q;

	// ========================================================
	// Checks
	dark_reset_a: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		st_q == fbm_pkg::ST_OFF |=> !led_q.run_led && !led_q.data_exchange_indicator)
		else $error("Indicators lit while inactive.");
	online_a: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		st_q == fbm_pkg::ST_OFF && ctrl_q[fbm_pkg::CTRL_BUSPAR]
		|=> st_q == fbm_pkg::ST_ONLINE ##1 led_q.run_led)
		else $error("Master did not go online.");
	xchg_a: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		st_q == fbm_pkg::ST_ONLINE && ctrl_q[1:0] == 2'b11
		|=> st_q == fbm_pkg::ST_XCHG)
		else $error("Exchange not started.");
	run_tel_a: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		tel_q.valid && tel_q.operate |-> !tel_q.zero_len)
		else $error("Run telegram shortened.");
	fsafe_a: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		tel_q.valid && !tel_q.operate && fs_q[tel_q.slave]
		|-> tel_q.zero_len)
		else $error("Fail-safe slave got data in stop.");
	stop_zero_a: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		tel_q.valid && !tel_q.operate && !fs_q[tel_q.slave]
		|-> tel_q.zero_data && !tel_q.zero_len)
		else $error("Stop telegram carried data.");
	odis_zero_a: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		tel_d.valid && ctrl_q[fbm_pkg::CTRL_ODIS] |=> tel_q.zero_data)
		else $error("Output disable ignored.");
	fail_evt_a: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		tel_d.valid && alive_q[slot_q] && !slave_resp_i[slot_q]
		|=> irq_q[fbm_pkg::IRQ_FAIL])
		else $error("Slave failure not flagged.");
	addr1_a: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		addr_q != 6'h01)
		else $error("Reserved address taken.");
	gop_follow_a: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		cyc_cnt_q == 16'(CYCLE_CYC - 1) && st_q == fbm_pkg::ST_XCHG
		|=> gop_q == $past(ctrl_q[fbm_pkg::CTRL_RUN]))
		else $error("Global command does not follow run state.");
	de_steady_a: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		st_q == fbm_pkg::ST_XCHG && run_lat_q |=> led_q.data_exchange_indicator)
		else $error("Exchange lamp dark in run.");
	copy_live_a: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		tel_d.valid |=> icopy_q == $past(slave_resp_i[slot_q]))
		else $error("Input copy does not follow the slave answer.");
	irq_level_a: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		|(irq_q & mask_q) |=> irq_out_q)
		else $error("Unmasked event did not raise the interrupt.");
endmodule
`default_nettype wire

//--- sim/fbm_slaves.sv
// Purpose: Behavioural model of the slave stations on the segment.
// Assumes: One answer bit per slave, refreshed in that slave's slot.
// Notes:   A slave that the bench marks dead stops answering.
`default_nettype none
module fbm_slaves (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Telegrams from the master and bench control
	input  wire fbm_pkg::fbm_tel_t tel_i,
	input  wire logic [7:0]  alive_i,
	// Answers
	output logic      [7:0]  resp_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Slaves use the master's rate and hold legal addresses above one.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			resp_o <= 8'h00;
		else if (tel_i.valid)
			resp_o[tel_i.slave] <= alive_i[tel_i.slave];
	end
endmodule
`default_nettype wire

//--- sim/fbm_top_bench.sv
// Purpose: Self-checking bench of the run/stop control.
// Assumes: Bus cycle shortened to 32 clocks, blink toggle interval to 8.
// Notes:   Telegrams are checked only once a run change has settled.
`default_nettype none
module fbm_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CYC = 32;
	logic clk = 0, rst = 1, rd = 0, wr = 0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wd = 32'h0, rdata, q;
	logic wq, gop, icp, irq;
	logic [7:0] resp, alive = 8'h00, sl, fs;
	fbm_pkg::fbm_tel_t tel;
	fbm_pkg::fbm_led_t led;
	int mismatches = 0, checks = 0, cyc = 0, tcnt, icnt, dtog;
	logic run_m = 0, odis_m = 0, chk_on = 0, de_l = 0;
	always #2 clk = ~clk;
	fbm_top #(.BLINK_CYC(8), .CYCLE_CYC(CYC)) dut_u (
		.sys_clk_i(clk), .rst_i(rst), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wq),
		.slave_resp_i(resp), .tel_o(tel), .global_operate_o(gop),
		.input_copy_o(icp), .led_o(led), .irq_o(irq));
	fbm_slaves part_u (.clk_i(clk), .rst_i(rst), .tel_i(tel),
		.alive_i(alive), .resp_o(resp));
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [31:0] e, g);
		checks++;
		if (e !== g) begin
			mismatches++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	// Request is held until the edge that samples waitrequest low; read
	// data are taken at that same edge and only then is it released.
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		adr <= a;
		wd <= d;
		do @(posedge clk); while (wq !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic rdc(input string n, input logic [3:0] a,
		input logic [31:0] e);
		bus(0, a, 32'h0);
		cmp(n, e, q);
	endtask
	task automatic bcyc(input int n);
		repeat (n * CYC) @(posedge clk);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc > 40000) begin
			mismatches++;
			give_verdict;
		end
	end
	// Telegram model, compared at every valid telegram once settled.
	always @(negedge clk) begin
		if (led.data_exchange_indicator !== de_l)
			dtog++;
		de_l = led.data_exchange_indicator;
		if (icp === 1'b1)
			icnt++;
		if (chk_on && tel.valid === 1'b1) begin
			tcnt++;
			cmp("slot en", 1'b1, sl[tel.slave]);
			cmp("operate", run_m, tel.operate);
			cmp("zero len", !run_m && fs[tel.slave], tel.zero_len);
			cmp("zero data", odis_m || (!run_m && !fs[tel.slave]),
				tel.zero_data);
		end
	end
	task automatic mode(input logic [3:0] c);
		chk_on = 0;
		bus(1, fbm_pkg::ADDR_CTRL, {28'h0, c});
		run_m = c[fbm_pkg::CTRL_RUN];
		odis_m = c[fbm_pkg::CTRL_ODIS];
		bcyc(2);
		tcnt = 0;
		icnt = 0;
		dtog = 0;
		chk_on = 1;
		bcyc(3);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		void'($urandom(73050));
		cmp("leds", 3'h0, led);
		rdc("stat off", fbm_pkg::ADDR_STAT, 32'h0);
		rdc("addr rst", fbm_pkg::ADDR_ADDR, 32'h2);
		bus(1, fbm_pkg::ADDR_ADDR, 32'h1);
		rdc("addr one", fbm_pkg::ADDR_ADDR, 32'h2);
		bus(1, fbm_pkg::ADDR_CTRL, 32'h1);
		bcyc(1);
		rdc("stat online", fbm_pkg::ADDR_STAT, 32'h1);
		cmp("run led", 1'b1, led.run_led);
		// Slave 0 lacks fail-safe and slave 1 has it; the rest is random.
		sl = 8'($urandom) | 8'h03;
		fs = (8'($urandom) | 8'h02) & 8'hFE;
		alive <= sl;
		bus(1, fbm_pkg::ADDR_SLAVES, {24'h0, sl});
		bus(1, fbm_pkg::ADDR_FSAFE, {24'h0, fs});
		bus(1, fbm_pkg::ADDR_MASK, 32'h3);
		mode(4'h7);
		rdc("stat xchg", fbm_pkg::ADDR_STAT, 32'h3);
		cmp("gop run", 1'b1, gop);
		cmp("de steady", 0, dtog);
		cmp("tel seen", 1'b1, tcnt > 0);
		cmp("copy run", 1'b1, icnt > 0);
		mode(4'h3);
		cmp("gop stop", 1'b0, gop);
		cmp("de blink", 1'b1, dtog > 0);
		cmp("copy stop", 1'b1, icnt > 0);
		mode(4'hF);
		cmp("gop odis", 1'b1, gop);
		bus(1, fbm_pkg::ADDR_IRQ, 32'h3);
		rdc("irq clr", fbm_pkg::ADDR_IRQ, 32'h0);
		alive <= sl & 8'hFE;
		bcyc(3);
		cmp("err led", 1'b1, led.err_led);
		rdc("alive drop", fbm_pkg::ADDR_ALIVE, {24'h0, alive});
		rdc("irq fail", fbm_pkg::ADDR_IRQ, 32'h1);
		cmp("irq on", 1'b1, irq);
		bus(1, fbm_pkg::ADDR_MASK, 32'h0);
		// The level output follows a mask change one edge later.
		repeat (2) @(posedge clk);
		cmp("irq mask", 1'b0, irq);
		bus(1, fbm_pkg::ADDR_MASK, 32'h3);
		alive <= sl;
		bcyc(3);
		rdc("irq join", fbm_pkg::ADDR_IRQ, 32'h3);
		rdc("alive back", fbm_pkg::ADDR_ALIVE, {24'h0, sl});
		bus(1, fbm_pkg::ADDR_IRQ, 32'h3);
		rdc("irq w1c", fbm_pkg::ADDR_IRQ, 32'h0);
		cmp("irq off", 1'b0, irq);
		cmp("err off", 1'b0, led.err_led);
		bus(1, fbm_pkg::ADDR_BAUD, 32'h9);
		bus(1, fbm_pkg::ADDR_BAUD, 32'hA);
		rdc("baud", fbm_pkg::ADDR_BAUD, 32'h9);
		rdc("unmapped", 4'hF, 32'h0);
		bus(1, fbm_pkg::ADDR_OUTLEN, 32'h5A);
		rdc("outlen", fbm_pkg::ADDR_OUTLEN, 32'h5A);
		bus(1, fbm_pkg::ADDR_CTRL, 32'h0);
		bcyc(1);
		rdc("stat idle", fbm_pkg::ADDR_STAT, 32'h0);
		cmp("leds idle", 3'h0, led);
		give_verdict;
	end
endmodule
`default_nettype wire
